// ===== rtl/htm_pkg.sv
// What this block does
// - On-request: convert only on host command
// - Automatic mode wakes itself each rate interval
// - On-request plus seven periodic rate choices
// - Humidity, temperature resolution 9/11/14 bits separately
// - Conversion length follows configured resolution
// - Host-controlled heater enable, on and off
// - Ignore bus glitches up to 50 ns
// - Power-up enters sleep, waits for host
package htm_pkg;
    // Clock rate in MHz
    localparam int unsigned CLK_MHZ        = 100;
    // Glitch width to reject, ns
    localparam int unsigned GLITCH_NS      = 50;
    // Stable cycles needed before a bus level is accepted
    localparam int unsigned GLITCH_CYC     = (GLITCH_NS * CLK_MHZ + 999) / 1000 + 1;
    // Conversion times in us, humidity then temperature
    localparam int unsigned HUM_CT_9_US    = 275;
    localparam int unsigned HUM_CT_11_US   = 400;
    localparam int unsigned HUM_CT_14_US   = 660;
    localparam int unsigned TMP_CT_9_US    = 225;
    localparam int unsigned TMP_CT_11_US   = 350;
    localparam int unsigned TMP_CT_14_US   = 610;
    // Rate periods in ms for codes 1..7 (5, 2, 1, 0.2, 0.1 Hz, 1/60, 1/120 Hz)
    localparam int unsigned PER_1_MS       = 200;
    localparam int unsigned PER_2_MS       = 500;
    localparam int unsigned PER_3_MS       = 1000;
    localparam int unsigned PER_4_MS       = 5000;
    localparam int unsigned PER_5_MS       = 10000;
    localparam int unsigned PER_6_MS       = 60000;
    localparam int unsigned PER_7_MS       = 120000;
    // Timebase: one tick per microsecond
    localparam int unsigned TICK_CYC       = CLK_MHZ;
    // Rate code for on-request operation
    localparam logic [2:0]  RATE_ON_REQ    = 3'h0;
    // Resolution codes
    localparam logic [1:0]  RES_14         = 2'h0;
    localparam logic [1:0]  RES_11         = 2'h1;
    localparam logic [1:0]  RES_9          = 2'h2;
    // Sequencer states
    typedef enum logic [2:0] {
        HTM_SLEEP = 3'h1,
        HTM_HUM   = 3'h2,
        HTM_TMP   = 3'h4
    } htm_state_t;
endpackage

// ===== rtl/htm_glitch_filter.sv
`timescale 1ns/10ps
// Synchronises a pin and accepts a new level only once it has held
module htm_glitch_filter
    import htm_pkg::*;
#(
    parameter int unsigned STABLE = htm_pkg::GLITCH_CYC
)(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Pin in, filtered level out
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed {
        logic       s1;   // First synchroniser stage
        logic       s2;   // Second synchroniser stage
        logic [7:0] cnt;  // Cycles the new level has held
        logic       lvl;  // Accepted level
    } htm_gf_t;
    htm_gf_t st_q, st_d;
    ////////////////////////////////////////////////////////////////
    // Next state: a pulse shorter than STABLE cycles never reaches lvl
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        if (st_q.s2 == st_q.lvl)
        begin
            st_d.cnt = 8'h00;
        end
        else if (st_q.cnt >= 8'(STABLE - 1))
        begin
            st_d.lvl = st_q.s2;
            st_d.cnt = 8'h00;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end
    // Register; idle bus level is high
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st_q <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, lvl: 1'b1};
        else
            st_q <= st_d;
    end
    assign level_o = st_q.lvl;
    ////////////////////////////////////////////////////////////////
    property p_glitch_hold;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(st_q.lvl) |-> $past(st_q.s2, 1) == st_q.lvl
            && $past(st_q.s2, 2) == st_q.lvl && $past(st_q.s2, 5) == st_q.lvl;
    endproperty
    a_glitch_hold: assert property (p_glitch_hold) else $error("short pulse taken");
endmodule

// ===== rtl/htm_sequencer.sv
`timescale 1ns/10ps
// Measurement sequencer: sleep, humidity conversion, temperature conversion
module htm_sequencer
    import htm_pkg::*;
#(
    parameter int unsigned TICK     = htm_pkg::TICK_CYC,  // Cycles per microsecond tick
    parameter int unsigned MS_TICKS = 1000                // Ticks per millisecond
)(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Serial bus pins, raw (filtered inside)
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_filt,
    output logic            sda_filt,
    // Control from the bus register logic
    input  wire logic       meas_trig,         // One-cycle start request
    input  wire logic [2:0] output_sample_rate,
    input  wire logic [1:0] hum_res,
    input  wire logic [1:0] tmp_res,
    input  wire logic       hum_en,            // Convert humidity
    input  wire logic       tmp_en,            // Convert temperature
    input  wire logic       heater_en_i,
    // Status
    output logic            heater_on,
    output logic            asleep,
    output logic            converting,
    output logic            hum_done,          // One-cycle pulse
    output logic            tmp_done           // One-cycle pulse
);
    import htm_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Duration helpers
    function automatic logic [9:0] hum_ct(input logic [1:0] r);
        case (r)
            RES_9:   hum_ct = 10'(HUM_CT_9_US);
            RES_11:  hum_ct = 10'(HUM_CT_11_US);
            default: hum_ct = 10'(HUM_CT_14_US);
        endcase
    endfunction
    function automatic logic [9:0] tmp_ct(input logic [1:0] r);
        case (r)
            RES_9:   tmp_ct = 10'(TMP_CT_9_US);
            RES_11:  tmp_ct = 10'(TMP_CT_11_US);
            default: tmp_ct = 10'(TMP_CT_14_US);
        endcase
    endfunction
    function automatic logic [16:0] period_ms(input logic [2:0] r);
        case (r)
            3'h1:    period_ms = 17'(PER_1_MS);
            3'h2:    period_ms = 17'(PER_2_MS);
            3'h3:    period_ms = 17'(PER_3_MS);
            3'h4:    period_ms = 17'(PER_4_MS);
            3'h5:    period_ms = 17'(PER_5_MS);
            3'h6:    period_ms = 17'(PER_6_MS);
            default: period_ms = 17'(PER_7_MS);
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    // Glitch filters for the two bus inputs
    logic scl_lvl;   // Filtered clock level
    logic sda_lvl;   // Filtered data level
    htm_glitch_filter u_scl (.core_clk(core_clk), .rst_n(rst_n), .pin_i(scl_i), .level_o(scl_lvl));
    htm_glitch_filter u_sda (.core_clk(core_clk), .rst_n(rst_n), .pin_i(sda_i), .level_o(sda_lvl));
    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        htm_state_t  state;     // Sequencer state
        logic [6:0]  pre;       // Cycle divider to microsecond tick
        logic [9:0]  conv;      // Conversion microseconds left
        logic [9:0]  us;        // Microseconds within the current ms
        logic [16:0] ms;        // Milliseconds since last auto wake
        logic [2:0]  rate;      // Rate seen last cycle
        logic        heat;      // Heater drive
        logic        hdone;     // Humidity done pulse
        logic        tdone;     // Temperature done pulse
        logic        scl;       // Output copies of filtered pins
        logic        sda;
    } htm_seq_t;
    htm_seq_t st_q, st_d;
    logic tick;      // One-cycle microsecond enable
    logic wake;      // Automatic wake-up request
    logic start;     // Any request to leave sleep
    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_d       = st_q;
        st_d.hdone = 1'b0;
        st_d.tdone = 1'b0;
        st_d.scl   = scl_lvl;
        st_d.sda   = sda_lvl;
        st_d.rate  = output_sample_rate;
        st_d.heat  = heater_en_i;
        tick       = (st_q.pre == 7'(TICK - 1));
        st_d.pre   = tick ? 7'h00 : st_q.pre + 7'h01;
        wake       = 1'b0;
        // Interval timer, restarted on any rate change
        if (output_sample_rate != st_q.rate || output_sample_rate == RATE_ON_REQ)
        begin
            st_d.us = 10'h000;
            st_d.ms = 17'h00000;
        end
        else if (tick)
        begin
            if (st_q.us == 10'(MS_TICKS - 1))
            begin
                st_d.us = 10'h000;
                if (st_q.ms == period_ms(st_q.rate) - 17'h00001)
                begin
                    st_d.ms = 17'h00000;
                    wake    = 1'b1;
                end
                else
                    st_d.ms = st_q.ms + 17'h00001;
            end
            else
                st_d.us = st_q.us + 10'h001;
        end
        // In on-request mode only the host command starts work
        start = (output_sample_rate == RATE_ON_REQ) ? meas_trig : wake;
        case (st_q.state)
            HTM_SLEEP:
            begin
                if (start && hum_en)
                begin
                    st_d.state = HTM_HUM;
                    st_d.conv  = hum_ct(hum_res);
                end
                else if (start && tmp_en)
                begin
                    st_d.state = HTM_TMP;
                    st_d.conv  = tmp_ct(tmp_res);
                end
            end
            HTM_HUM:
            begin
                if (tick)
                begin
                    if (st_q.conv <= 10'h001)
                    begin
                        st_d.hdone = 1'b1;
                        st_d.state = tmp_en ? HTM_TMP : HTM_SLEEP;
                        st_d.conv  = tmp_ct(tmp_res);
                    end
                    else
                        st_d.conv = st_q.conv - 10'h001;
                end
            end
            HTM_TMP:
            begin
                if (tick)
                begin
                    if (st_q.conv <= 10'h001)
                    begin
                        st_d.tdone = 1'b1;
                        st_d.state = HTM_SLEEP;
                    end
                    else
                        st_d.conv = st_q.conv - 10'h001;
                end
            end
            default:
                st_d.state = HTM_SLEEP;
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // Register; power-up lands in sleep with heater off
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_q       <= '0;
            st_q.state <= HTM_SLEEP;
            st_q.scl   <= 1'b1;
            st_q.sda   <= 1'b1;
        end
        else
            st_q <= st_d;
    end
    // Outputs from flops; asleep and converting are decoded from the state flops
    assign heater_on  = st_q.heat;
    assign asleep     = (st_q.state == HTM_SLEEP);
    assign converting = (st_q.state != HTM_SLEEP);
    assign hum_done   = st_q.hdone;
    assign tmp_done   = st_q.tdone;
    assign scl_filt   = st_q.scl;
    assign sda_filt   = st_q.sda;
    ////////////////////////////////////////////////////////////////
    property p_no_req_start;
        @(posedge core_clk) disable iff (!rst_n)
        ($past(output_sample_rate) == RATE_ON_REQ && $rose(converting)) |-> $past(meas_trig);
    endproperty
    a_no_req_start: assert property (p_no_req_start) else $error("start unasked");
    property p_auto_start;
        @(posedge core_clk) disable iff (!rst_n)
        (wake && asleep && hum_en) |=> converting;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("auto wake missed");
    property p_sleep_after;
        @(posedge core_clk) disable iff (!rst_n)
        tmp_done |-> asleep;
    endproperty
    a_sleep_after: assert property (p_sleep_after) else $error("awake after result");
    property p_hum_len;
        @(posedge core_clk) disable iff (!rst_n)
        (asleep && start && hum_en && hum_res == RES_9) |=> (st_q.conv == 10'(HUM_CT_9_US));
    endproperty
    a_hum_len: assert property (p_hum_len) else $error("humidity length wrong");
    property p_tmp_len;
        @(posedge core_clk) disable iff (!rst_n)
        (hum_done && tmp_en && tmp_res == RES_11) |-> (st_q.conv == 10'(TMP_CT_11_US));
    endproperty
    a_tmp_len: assert property (p_tmp_len) else $error("temperature length wrong");
    property p_heater;
        @(posedge core_clk) disable iff (!rst_n)
        heater_en_i |=> heater_on;
    endproperty
    a_heater: assert property (p_heater) else $error("heater not following");
    property p_restart;
        @(posedge core_clk) disable iff (!rst_n)
        (output_sample_rate != st_q.rate) |=> (st_q.ms == 17'h00000 && st_q.us == 10'h000);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");
    property p_period;
        @(posedge core_clk) disable iff (!rst_n)
        wake |-> st_q.ms == period_ms(st_q.rate) - 17'h00001;
    endproperty
    a_period: assert property (p_period) else $error("wake at wrong interval");
    property p_reset_sleep;
        @(posedge core_clk)
        !rst_n |=> asleep;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep) else $error("awake after reset");
endmodule

// ===== dv/htm_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Host side: control levels and bus pins, all moved on the falling edge
module htm_host_model
#(
    parameter int unsigned START_WAIT = 12  // Power-up wait, scaled like the timebase
)(
    // Clock
    input  wire logic       core_clk,
    // Control levels toward the sequencer
    output logic            meas_trig,
    output logic [2:0]      output_sample_rate,
    output logic [1:0]      hum_res,
    output logic [1:0]      tmp_res,
    output logic            hum_en,
    output logic            tmp_en,
    output logic            heater_en_i,
    // Bus pins; pulled up, so released means high
    output logic            scl_i,
    output logic            sda_i
);
    // Everything idle at time zero
    initial
    begin
        {meas_trig, output_sample_rate, hum_res, tmp_res} = 8'h00;
        {hum_en, tmp_en, heater_en_i} = 3'h0;
        {scl_i, sda_i} = 2'h3;
    end
    // Hold off measurements until the part is ready
    task automatic startup_wait();
        repeat (START_WAIT) @(negedge core_clk);
    endtask
    // Configuration lands as one change
    task automatic setup(input logic [2:0] r, input logic [1:0] hr, input logic [1:0] tr,
                         input logic he, input logic te);
        @(negedge core_clk);
        output_sample_rate = r;
        hum_res = hr;
        tmp_res = tr;
        hum_en = he;
        tmp_en = te;
    endtask
    // One-cycle start request
    task automatic trigger();
        @(negedge core_clk);
        meas_trig = 1'h1;
        @(negedge core_clk);
        meas_trig = 1'h0;
    endtask
    // Heater level; the bench keeps measuring while it is on
    task automatic heater(input logic v);
        @(negedge core_clk);
        heater_en_i = v;
    endtask
    // Pull one pin low for w ns, then let the pull-up restore it
    task automatic pulse(input logic p, input int unsigned w);
        @(negedge core_clk);
        if (p)
            sda_i = 1'h0;
        else
            scl_i = 1'h0;
        #(w);
        {scl_i, sda_i} = 2'h3;
    endtask
endmodule

// ===== dv/htm_sequencer_test.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module htm_sequencer_test;
    import htm_pkg::*;
    localparam int unsigned TK = 2;  // Cycles per tick, shortened
    localparam int unsigned MT = 2;  // Ticks per ms, shortened
    // Expected completion: which quantity, and its cycle window
    typedef struct packed {logic is_hum; int unsigned lo; int unsigned hi;} htm_note_t;
    logic        core_clk = 1'h0;
    logic        rst_n    = 1'h0;
    logic        meas_trig, hum_en, tmp_en, heater_en_i, scl_i, sda_i;
    logic [2:0]  output_sample_rate;
    logic [1:0]  hum_res, tmp_res;
    logic        scl_filt, sda_filt, heater_on, asleep, converting, hum_done, tmp_done;
    htm_note_t   notes[$];
    htm_note_t   cur;
    logic        conv_prev = 1'h0;
    int unsigned since = 0, failures = 0, checks = 0;
    logic [31:0] seed = 32'h2A412C6E;
    logic        seen0;
    int unsigned cnt;
    always #5 core_clk = ~core_clk;
    htm_sequencer #(.TICK(TK), .MS_TICKS(MT)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
        .scl_filt(scl_filt), .sda_filt(sda_filt), .meas_trig(meas_trig),
        .output_sample_rate(output_sample_rate), .hum_res(hum_res), .tmp_res(tmp_res),
        .hum_en(hum_en), .tmp_en(tmp_en), .heater_en_i(heater_en_i), .heater_on(heater_on),
        .asleep(asleep), .converting(converting), .hum_done(hum_done), .tmp_done(tmp_done));
    htm_host_model #(.START_WAIT(3 * MT * TK)) host (
        .core_clk(core_clk), .meas_trig(meas_trig), .output_sample_rate(output_sample_rate),
        .hum_res(hum_res), .tmp_res(tmp_res), .hum_en(hum_en), .tmp_en(tmp_en),
        .heater_en_i(heater_en_i), .scl_i(scl_i), .sda_i(sda_i));
    ////////////////////////////////////////////////////////////////////////////
    // Count every comparison, report each mismatch
    task automatic check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask
    // Next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Conversion length in cycles; codes 0 and 3 both mean 14 bits
    function automatic int unsigned ct(input logic h, input logic [1:0] r);
        if (r == RES_9) return TK * (h ? HUM_CT_9_US : TMP_CT_9_US);
        if (r == RES_11) return TK * (h ? HUM_CT_11_US : TMP_CT_11_US);
        return TK * (h ? HUM_CT_14_US : TMP_CT_14_US);
    endfunction
    // Rate period in ms for the codes short enough to wait out
    function automatic int unsigned per_ms(input int k);
        if (k == 1) return PER_1_MS;
        if (k == 2) return PER_2_MS;
        if (k == 3) return PER_3_MS;
        return PER_4_MS;
    endfunction
    // Window allows for the free-running tick divider
    task automatic expect_conv(input logic h, input logic [1:0] r);
        notes.push_back('{h, ct(h, r) - 3, ct(h, r) + TK + 4});
    endtask
    // Bounded wait for the return to sleep, then nothing may be owed
    task automatic wait_sleep();
        for (int i = 0; i < 4000; i++)
        begin
            @(negedge core_clk);
            if (asleep === 1'h1 && notes.size() == 0) break;
        end
        check(notes.size() == 0, 1'h1);
    endtask
    // Cycles from now until wake-up, against a period of p cycles
    task automatic wait_wake(input int unsigned p);
        cnt = 0;
        while (asleep === 1'h1 && cnt < p + 50)
        begin
            @(negedge core_clk);
            cnt++;
        end
        check(cnt >= p - 3 && cnt <= p + TK + 4, 1'h1);
    endtask
    // Watch one filtered pin while the host pulses it for w ns
    task automatic glitch(input logic p, input int unsigned w);
        seen0 = 1'h0;
        fork
            host.pulse(p, w);
            repeat (45) @(negedge core_clk) if ((p ? sda_filt : scl_filt) === 1'h0) seen0 = 1'h1;
        join
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Monitor: each completion takes the oldest note off the queue
    always @(negedge core_clk)
    begin
        since = (converting === 1'h1 && conv_prev !== 1'h1) ? 1 : since + 1;
        conv_prev = converting;
        if (hum_done === 1'h1 || tmp_done === 1'h1)
        begin
            if (notes.size() == 0)
                check(1'h1, 1'h0);
            else
            begin
                cur = notes.pop_front();
                check(hum_done, cur.is_hum);
                check(since >= cur.lo && since <= cur.hi, 1'h1);
            end
            since = 0;
        end
    end
    // Watchdog, well past the expected run length
    initial
    begin
        repeat (60000) @(posedge core_clk);
        failures++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'h1;
        @(negedge core_clk);
        check(asleep, 1'h1);
        check(converting | heater_on, 1'h0);
        host.startup_wait();
        // Enabled but never commanded: no conversion may start
        host.setup(RATE_ON_REQ, RES_14, RES_14, 1'h1, 1'h1);
        repeat (1500) @(negedge core_clk);
        check(asleep, 1'h1);
        // Random heater levels, each copied one cycle later
        for (int i = 0; i < 30; i++)
        begin
            seed = lfsr(seed);
            host.heater(seed[0]);
            @(negedge core_clk);
            check(heater_on, seed[0]);
        end
        host.heater(1'h1);
        // Every resolution code on each quantity; second request mid-run is ignored
        for (int r = 0; r < 4; r++)
        begin
            host.setup(RATE_ON_REQ, 2'(r), 2'(3 - r), 1'h1, 1'h1);
            expect_conv(1'h1, 2'(r));
            expect_conv(1'h0, 2'(3 - r));
            host.trigger();
            repeat (100) @(negedge core_clk);
            host.trigger();
            wait_sleep();
        end
        host.heater(1'h0);
        // Temperature alone
        host.setup(RATE_ON_REQ, RES_11, RES_9, 1'h0, 1'h1);
        expect_conv(1'h0, RES_9);
        host.trigger();
        wait_sleep();
        // Automatic mode; the rate change part-way restarts the interval
        host.setup(3'h2, RES_9, RES_9, 1'h1, 1'h0);
        repeat (1000) @(negedge core_clk);
        check(asleep, 1'h1);
        for (int k = 1; k < 5; k++)
        begin
            expect_conv(1'h1, RES_9);
            host.setup(3'(k), RES_9, RES_9, 1'h1, 1'h0);
            wait_wake(TK * MT * per_ms(k));
            wait_sleep();
        end
        // Slowest rates are too long to wait out; each restarts with no early wake
        for (int k = 5; k < 8; k++)
        begin
            host.setup(3'(k), RES_9, RES_9, 1'h1, 1'h0);
            repeat (200) @(negedge core_clk);
            check(asleep, 1'h1);
        end
        host.setup(RATE_ON_REQ, RES_9, RES_9, 1'h1, 1'h0);
        // Spikes up to the full 50 ns limit are dropped, a real low gets through
        for (int p = 0; p < 2; p++)
        begin
            glitch(1'(p), 50);
            check(seen0, 1'h0);
            glitch(1'(p), 300);
            check(seen0, 1'h1);
        end
        complete_run();
    end
endmodule
